// File: logic/byte_ram.sv
`timescale 1ns/1ps
module byte_ram #(
  parameter int AW = 8
) (
  input wire logic mclk,
  mem_if.mem port
);
  // contents are not reset: volatile cells start undefined
  logic [7:0] cells [0:(1<<AW)-1];
  logic [7:0] rdata;

  always_ff @(posedge mclk) begin
    if (port.we) begin
      cells[port.addr] <= port.wdata;
    end
    rdata <= cells[port.addr];
  end

  assign port.rdata = rdata;
endmodule : byte_ram

// File: logic/data_memory_space_decoder.sv
`timescale 1ns/1ps
// Contract
// [R1] lower 128 bytes reachable at 00h-7Fh by direct and indirect access
// [R2] lowest 32 bytes form four banks of eight working registers
// [R3] bank select 00,01,10,11 maps registers to 00h,08h,10h,18h bases
// [R4] 16 bytes above banks hold 128 bits, bit addresses 00h-7Fh
// [R5] upper 128 bytes only indirect; direct 80h-FFh goes elsewhere
// [R6] 2048 bytes expanded ram at 0000h-07FFh via external moves only
// [R7] external ram select 0 routes to expanded ram, 1 to external bus
// [R8] software sets expanded ram size; full 2048 bytes after reset
// [R9] size codes 256,512,768,1024,1792,2048; 110/111 reserved; reset 101
// [R10] high address on port 2, low address multiplexed with data on port 0
// [R11] address latch strobe marks valid low address on port 0
// [R12] separate read strobe and write strobe outputs for external access
// [R13] external memory cycle lasts six cpu clock periods
// [R14] stretch bit widens strobes from 3 to 15 cpu clock periods
// [R15] register-pointer external move keeps port 2 register on port 2
// [R16] two 16-bit pointers share 83h/84h; only selected one visible
// [R17] pointer select bit picks pointer for accesses and external moves
// [R18] incrementing auxiliary control register toggles pointer select
// [R19] bit above pointer select reads 0 so increment never carries
// [R20] strobe free-runs at 1/6 osc unless disabled; then only on moves
// [R21] strobes active low, never both; address before and through strobe
// [R22] memory latches on strobe fall, drives port 0 only while read low
// [R23] write data driven after address phase, held through write strobe
module data_memory_space_decoder
  import dmem_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  // internal ram access
  input wire logic int_req,
  input wire logic int_we,
  input wire acc_mode_t int_mode,
  input wire logic [7:0] int_addr,
  input wire logic [7:0] int_wdata,
  input wire logic int_bit_wdata,
  input wire logic bank_select_low,
  input wire logic bank_select_high,
  output logic [7:0] int_rdata,
  output logic int_rbit,
  output logic int_done,
  output logic direct_to_sfr,
  // special register port
  input wire logic sfr_rd,
  input wire logic sfr_wr,
  input wire logic sfr_inc,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic data_pointer_inc,
  // external move
  input wire logic x_req,
  input wire logic x_we,
  input wire logic x_use_pointer,
  input wire logic [7:0] x_ri_addr,
  input wire logic [7:0] x_wdata,
  input wire logic [7:0] high_address_port_reg,
  output logic [7:0] x_rdata,
  output logic x_done,
  output logic busy,
  // pins
  output logic ale,
  output logic rd_n,
  output logic wr_n,
  output logic [7:0] low_address_data_port_out,
  output logic low_address_data_port_oe,
  input wire logic [7:0] low_address_data_port_in,
  output logic [7:0] high_address_port
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    state_t st;
    logic [4:0] c;
    logic [1:0] div;
    logic [15:0] dptr0;
    logic [15:0] dptr1;
    logic psel;
    logic gflag;
    logic stretch;
    logic [2:0] size;
    logic external_ram_select;
    logic ale_dis;
    logic ale;
    logic rd_n;
    logic wr_n;
    logic [7:0] p0_out;
    logic p0_oe;
    logic [7:0] p2_out;
    logic [7:0] p0_s1;
    logic [7:0] p0_s2;
    logic [15:0] xaddr;
    logic xwe;
    logic [7:0] xwd;
    logic [7:0] x_rdata;
    logic x_done;
    logic [7:0] iaddr;
    logic iwe;
    logic is_bit;
    logic [2:0] bitpos;
    logic ibit;
    logic [7:0] int_rdata;
    logic int_rbit;
    logic int_done;
    logic direct_sfr;
    logic [7:0] sfr_rdata;
  } regs_t;

  regs_t s;
  regs_t next_s;

  mem_if #(.AW(8)) iram ();
  mem_if #(.AW(11)) onchip_expanded_ram ();

  byte_ram #(.AW(8)) u_iram (.mclk(mclk), .port(iram.mem));
  byte_ram #(.AW(11)) u_onchip_expanded_ram (.mclk(mclk), .port(onchip_expanded_ram.mem));

  logic [15:0] ptr;
  logic [15:0] xaddr_now;
  logic in_onchip_expanded_ram;
  logic [7:0] sfr_cur;
  logic [7:0] sfr_new;
  logic [4:0] strobe_w;
  logic [4:0] nc;
  logic [7:0] merged;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.x_done = 1'b0;
    next_s.int_done = 1'b0;
    next_s.direct_sfr = 1'b0;
    // pin synchroniser: second stage is the only reader of the first
    next_s.p0_s1 = low_address_data_port_in;
    next_s.p0_s2 = s.p0_s1;

    ptr = s.psel ? s.dptr1 : s.dptr0; // [R17]
    xaddr_now = x_use_pointer ? ptr : {8'h00, x_ri_addr};
    // [R6] [R7]
    in_onchip_expanded_ram = !s.external_ram_select && (xaddr_now < {4'h0, onchip_expanded_ram_limit(s.size)});

    iram.addr = int_addr;
    iram.we = 1'b0;
    iram.wdata = int_wdata;
    onchip_expanded_ram.addr = xaddr_now[10:0];
    onchip_expanded_ram.we = 1'b0;
    onchip_expanded_ram.wdata = x_wdata;
    merged = s.int_rdata;
    merged[s.bitpos] = s.ibit;
    strobe_w = s.stretch ? STROBE_STRETCH : STROBE_NORMAL; // [R14]
    nc = s.c + 5'h01;

    // free-running latch strobe divider; the cpu clock is mclk, so
    // 1/6 osc (standard) and 1/3 osc (double speed) both give 1 in 3
    next_s.div = (s.div == ALE_DIV - 2'h1) ? 2'h0 : s.div + 2'h1;
    next_s.ale = !s.ale_dis && (next_s.div == 2'h0); // [R20]

    // special registers
    unique case (sfr_addr)
      PTR_HIGH_ADDR: sfr_cur = ptr[15:8]; // [R16]
      PTR_LOW_ADDR: sfr_cur = ptr[7:0]; // [R16]
      AUX_CONFIG_ADDR: sfr_cur = {2'b00, s.stretch, s.size, s.external_ram_select,
                                  s.ale_dis};
      // bit above select reads zero; an increment's carry stops there, short of gflag
      AUX_CONTROL_ADDR: sfr_cur = {4'h0, s.gflag, 1'b0, 1'b0,
                                   s.psel}; // [R19]
      default: sfr_cur = 8'h00;
    endcase
    sfr_new = sfr_inc ? sfr_cur + 8'h01 : sfr_wdata; // [R18]
    if (sfr_rd) begin
      next_s.sfr_rdata = sfr_cur;
    end
    if (data_pointer_inc) begin
      if (s.psel) begin
        next_s.dptr1 = s.dptr1 + 16'h0001;
      end else begin
        next_s.dptr0 = s.dptr0 + 16'h0001;
      end
    end
    if (sfr_wr || sfr_inc) begin
      unique case (sfr_addr)
        PTR_HIGH_ADDR: begin
          if (s.psel) next_s.dptr1[15:8] = sfr_new; // [R16]
          else next_s.dptr0[15:8] = sfr_new;
        end
        PTR_LOW_ADDR: begin
          if (s.psel) next_s.dptr1[7:0] = sfr_new; // [R16]
          else next_s.dptr0[7:0] = sfr_new;
        end
        AUX_CONFIG_ADDR: begin
          next_s.stretch = sfr_new[STRETCH_BIT];
          next_s.size = sfr_new[SIZE_LSB +: 3]; // [R8] [R9]
          next_s.external_ram_select = sfr_new[EXTERNAL_RAM_SELECT_BIT];
          next_s.ale_dis = sfr_new[ALE_DIS_BIT];
        end
        AUX_CONTROL_ADDR: begin
          next_s.psel = sfr_new[PSEL_BIT]; // [R18]
          next_s.gflag = sfr_new[GFLAG_BIT];
        end
        default: begin
        end
      endcase
    end

    unique case (s.st)
      S_IDLE: begin
        if (x_req) begin
          next_s.xaddr = xaddr_now;
          next_s.xwe = x_we;
          next_s.xwd = x_wdata;
          if (in_onchip_expanded_ram) begin
            onchip_expanded_ram.we = x_we;
            next_s.st = S_ONCHIP_EXPANDED_RAM;
          end else begin
            next_s.st = S_XBUS;
            next_s.c = 5'h00;
            next_s.ale = 1'b1; // [R11]
            next_s.p0_out = xaddr_now[7:0]; // [R10]
            next_s.p0_oe = 1'b1;
            // [R10] [R15]
            next_s.p2_out = x_use_pointer ? xaddr_now[15:8]
                                          : high_address_port_reg;
          end
        end else if (int_req) begin
          unique case (int_mode)
            ACC_DIRECT: iram.addr = int_addr; // [R1] [R5]
            ACC_INDIRECT: iram.addr = int_addr; // [R1] [R5]
            // [R2] [R3]
            ACC_REG: iram.addr = {3'h0, bank_select_high, bank_select_low,
                                  int_addr[2:0]};
            // [R4]
            ACC_BIT: iram.addr = BIT_AREA_BASE + {4'h0, int_addr[6:3]};
          endcase
          if ((int_mode == ACC_DIRECT || int_mode == ACC_BIT) &&
              int_addr > LOWER_TOP) begin
            next_s.direct_sfr = 1'b1; // [R5]
          end else begin
            iram.we = int_we && (int_mode != ACC_BIT);
            next_s.st = S_IRAM;
            next_s.iaddr = iram.addr;
            next_s.iwe = int_we;
            next_s.is_bit = (int_mode == ACC_BIT);
            next_s.bitpos = (int_mode == ACC_BIT) ? int_addr[2:0]
                                                  : BANK_REG_ZERO;
            next_s.ibit = int_bit_wdata;
          end
        end
      end
      S_IRAM: begin
        next_s.int_rdata = iram.rdata;
        next_s.int_rbit = iram.rdata[s.bitpos];
        if (s.is_bit && s.iwe) begin
          next_s.st = S_BITWR;
        end else begin
          next_s.int_done = 1'b1;
          next_s.st = S_IDLE;
        end
      end
      S_BITWR: begin
        // read-modify-write keeps the other seven bits of the byte
        iram.addr = s.iaddr;
        iram.wdata = merged; // [R4]
        iram.we = 1'b1;
        next_s.int_done = 1'b1;
        next_s.st = S_IDLE;
      end
      S_ONCHIP_EXPANDED_RAM: begin
        onchip_expanded_ram.addr = s.xaddr[10:0];
        if (!s.xwe) begin
          next_s.x_rdata = onchip_expanded_ram.rdata; // [R6]
        end
        next_s.x_done = 1'b1;
        next_s.st = S_IDLE;
      end
      S_XBUS: begin
        next_s.c = nc;
        next_s.ale = 1'b0; // [R11]
        if (nc == ADDR_PHASE) begin
          // address has been out for two cycles before either strobe
          next_s.rd_n = s.xwe; // [R12] [R21]
          next_s.wr_n = !s.xwe; // [R12] [R21]
          next_s.p0_out = s.xwd; // [R23]
          next_s.p0_oe = s.xwe; // [R22] [R23]
        end
        if (nc == ADDR_PHASE + strobe_w) begin
          next_s.rd_n = 1'b1;
          next_s.wr_n = 1'b1;
          if (!s.xwe) begin
            // synced copy lags the pins by two cycles, still in strobe
            next_s.x_rdata = s.p0_s2; // [R22]
          end
        end
        if (nc == ADDR_PHASE + strobe_w + HOLD_PHASE) begin // [R13] [R14]
          next_s.st = S_IDLE;
          next_s.c = 5'h00;
          next_s.p0_oe = 1'b0;
          next_s.x_done = 1'b1;
          next_s.ale = !s.ale_dis && (next_s.div == 2'h0); // [R20]
        end
      end
      default: begin
        next_s.st = S_IDLE;
        next_s.rd_n = 1'b1;
        next_s.wr_n = 1'b1;
        next_s.p0_oe = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.st <= S_IDLE;
      s.rd_n <= 1'b1;
      s.wr_n <= 1'b1;
      s.stretch <= AUX_CONFIG_RESET[STRETCH_BIT];
      s.size <= AUX_CONFIG_RESET[SIZE_LSB +: 3]; // [R8] [R9]
      s.external_ram_select <= AUX_CONFIG_RESET[EXTERNAL_RAM_SELECT_BIT];
      s.ale_dis <= AUX_CONFIG_RESET[ALE_DIS_BIT];
    end else begin
      s <= next_s;
    end
  end

  assign int_rdata = s.int_rdata;
  assign int_rbit = s.int_rbit;
  assign int_done = s.int_done;
  assign direct_to_sfr = s.direct_sfr;
  assign sfr_rdata = s.sfr_rdata;
  assign x_rdata = s.x_rdata;
  assign x_done = s.x_done;
  assign busy = (s.st != S_IDLE);
  assign ale = s.ale;
  assign rd_n = s.rd_n;
  assign wr_n = s.wr_n;
  assign low_address_data_port_out = s.p0_out;
  assign low_address_data_port_oe = s.p0_oe;
  assign high_address_port = s.p2_out;

endmodule : data_memory_space_decoder

// File: logic/dmem_pkg.sv
package dmem_pkg;

  // ---------------------------------------------------------------
  // internal ram map
  // ---------------------------------------------------------------
  localparam logic [7:0] LOWER_TOP = 8'h7f;
  localparam logic [7:0] BIT_AREA_BASE = 8'h20;
  localparam logic [2:0] BANK_REG_ZERO = 3'h0;

  // ---------------------------------------------------------------
  // special register addresses seen on the register port
  // ---------------------------------------------------------------
  localparam logic [7:0] PTR_HIGH_ADDR = 8'h83;
  localparam logic [7:0] PTR_LOW_ADDR = 8'h84;
  localparam logic [7:0] AUX_CONFIG_ADDR = 8'h8e;
  localparam logic [7:0] AUX_CONTROL_ADDR = 8'ha2;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int STRETCH_BIT = 5;
  localparam int SIZE_LSB = 2;
  localparam int EXTERNAL_RAM_SELECT_BIT = 1;
  localparam int ALE_DIS_BIT = 0;
  localparam logic [7:0] AUX_CONFIG_RESET = 8'h14;
  localparam int PSEL_BIT = 0;
  localparam int GFLAG_BIT = 3;

  // ---------------------------------------------------------------
  // bus timing, in cpu clock periods
  // ---------------------------------------------------------------
  localparam logic [4:0] ADDR_PHASE = 5'h02;
  localparam logic [4:0] STROBE_NORMAL = 5'h03;
  localparam logic [4:0] STROBE_STRETCH = 5'h0f;
  localparam logic [4:0] HOLD_PHASE = 5'h01;
  localparam logic [1:0] ALE_DIV = 2'h3;

  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_IRAM = 5'b00010,
    S_BITWR = 5'b00100,
    S_ONCHIP_EXPANDED_RAM = 5'b01000,
    S_XBUS = 5'b10000
  } state_t;

  typedef enum logic [1:0] {
    ACC_DIRECT = 2'h0,
    ACC_INDIRECT = 2'h1,
    ACC_REG = 2'h2,
    ACC_BIT = 2'h3
  } acc_mode_t;

  function automatic logic [11:0] onchip_expanded_ram_limit(input logic [2:0] size);
    case (size)
      3'h0: onchip_expanded_ram_limit = 12'h100;
      3'h1: onchip_expanded_ram_limit = 12'h200;
      3'h2: onchip_expanded_ram_limit = 12'h300;
      3'h3: onchip_expanded_ram_limit = 12'h400;
      3'h4: onchip_expanded_ram_limit = 12'h700;
      default: onchip_expanded_ram_limit = 12'h800;
    endcase
  endfunction : onchip_expanded_ram_limit

endpackage : dmem_pkg

// File: logic/mem_if.sv
`timescale 1ns/1ps
interface mem_if #(parameter int AW = 8);
  logic [AW-1:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic we;
  modport ctl(output addr, output wdata, output we, input rdata);
  modport mem(input addr, input wdata, input we, output rdata);
endinterface : mem_if

// File: tb/data_memory_space_decoder_tb.sv
`timescale 1ns/1ps
module data_memory_space_decoder_tb
  import dmem_pkg::*;
;
  localparam logic Y = 1'h1;
  localparam logic N = 1'h0;
  logic mclk = N, rst_n = N, ireq = N, iwe = N, ibit = N, bsl = N, bsh = N;
  logic srd = N, swr = N, sinc = N, dinc = N, xreq = N, xwe = N, xup = N;
  logic slow = N;
  acc_mode_t imode = ACC_DIRECT;
  logic [7:0] iaddr = 8'h00, iwd = 8'h00, sa = 8'h00, sd = 8'h00;
  logic [7:0] xri = 8'h00, xwd = 8'h00, p2r = 8'h00;
  logic [7:0] irdata, srdata, xrdata, p0o, p0i, p2, last_hi, r, b, h;
  logic irbit, idone, dsfr, xdone, busy, ale, rd_n, wr_n, p0e, s_seen;
  logic [8:0] q_i[$], q_s[$], q_x[$], e;
  int error_cnt = 0, compares = 0, i;
  always #12.5 mclk = ~mclk;
  data_memory_space_decoder dut (.mclk(mclk), .rst_n(rst_n),
    .int_req(ireq), .int_we(iwe), .int_mode(imode), .int_addr(iaddr),
    .int_wdata(iwd), .int_bit_wdata(ibit), .bank_select_low(bsl),
    .bank_select_high(bsh), .int_rdata(irdata), .int_rbit(irbit),
    .int_done(idone), .direct_to_sfr(dsfr), .sfr_rd(srd), .sfr_wr(swr),
    .sfr_inc(sinc), .sfr_addr(sa), .sfr_wdata(sd), .sfr_rdata(srdata),
    .data_pointer_inc(dinc), .x_req(xreq), .x_we(xwe), .x_use_pointer(xup),
    .x_ri_addr(xri), .x_wdata(xwd), .high_address_port_reg(p2r),
    .x_rdata(xrdata), .x_done(xdone), .busy(busy), .ale(ale),
    .rd_n(rd_n), .wr_n(wr_n), .low_address_data_port_out(p0o),
    .low_address_data_port_oe(p0e), .low_address_data_port_in(p0i),
    .high_address_port(p2));
  ext_mem mem (.mclk(mclk), .ale(ale), .rd_n(rd_n), .wr_n(wr_n),
    .slow(slow), .dout(p0o), .doe(p0e), .hi(p2), .din(p0i),
    .last_hi(last_hi));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict;
    if (error_cnt == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : give_verdict
  task automatic sfr(input logic rd, wr, inc, input logic [7:0] a, d, x);
    @(negedge mclk);
    {srd, swr, sinc, sa, sd} = {rd, wr, inc, a, d};
    if (rd)
      q_s.push_back({Y, x});
    @(negedge mclk);
    {srd, swr, sinc} = 3'h0;
  endtask : sfr
  task automatic iop(input logic w, input acc_mode_t m,
    input logic [7:0] a, d, input logic bt, c, input logic [7:0] x,
    input logic ds);
    int n;
    @(negedge mclk);
    imode = m;
    {ireq, iwe, iaddr, iwd, ibit} = {Y, w, a, d, bt};
    if (!ds)
      q_i.push_back({c, x});
    @(negedge mclk);
    ireq = N;
    for (n = 0; n < 20 && !(idone || dsfr); n++) @(negedge mclk);
    if (n == 20) begin
      error_cnt++;
      give_verdict();
    end
    check({7'h00, dsfr}, {7'h00, ds});
  endtask : iop
  task automatic xop(input logic w, u, input logic [7:0] ri, d, x);
    int n;
    @(negedge mclk);
    {xreq, xwe, xup, xri, xwd} = {Y, w, u, ri, d};
    q_x.push_back({!w, x});
    @(negedge mclk);
    xreq = N;
    for (n = 0; n < 40 && !xdone; n++) @(negedge mclk);
    if (n == 40) begin
      error_cnt++;
      give_verdict();
    end
  endtask : xop
  task automatic ptr(input logic [7:0] hi, lo);
    sfr(N, Y, N, PTR_HIGH_ADDR, hi, 8'h00);
    sfr(N, Y, N, PTR_LOW_ADDR, lo, 8'h00);
  endtask : ptr
  // ---------------------------------------------------------------
  // result watcher
  // ---------------------------------------------------------------
  always @(posedge mclk) s_seen <= srd;
  always @(negedge mclk) begin
    if (idone) begin
      e = q_i.pop_front();
      if (e[8])
        check(irdata, e[7:0]);
    end
    if (xdone) begin
      e = q_x.pop_front();
      if (e[8])
        check(xrdata, e[7:0]);
    end
    if (s_seen) begin
      e = q_s.pop_front();
      check(srdata, e[7:0]);
    end
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(37));
    repeat (12) @(negedge mclk);
    rst_n = Y;
    sfr(Y, N, N, AUX_CONFIG_ADDR, 8'h00, AUX_CONFIG_RESET);
    sfr(Y, N, N, AUX_CONTROL_ADDR, 8'h00, 8'h00);
    for (i = 0; i < 4; i++) begin
      {bsh, bsl} = i[1:0];
      r = 8'($urandom);
      b = 8'($urandom_range(7, 0));
      iop(Y, ACC_REG, b, r, N, N, 8'h00, N);
      iop(N, ACC_DIRECT, 8'(i * 8) + b, 8'h00, N, Y, r, N);
    end
    b = 8'($urandom_range(127, 0));
    iop(Y, ACC_DIRECT, 8'h20 + b[6:3], 8'h00, N, N, 8'h00, N);
    iop(Y, ACC_BIT, b, 8'h00, Y, N, 8'h00, N);
    iop(N, ACC_DIRECT, 8'h20 + b[6:3], 8'h00, N, Y, 8'h01 << b[2:0], N);
    iop(N, ACC_BIT, b, 8'h00, N, Y, 8'h01 << b[2:0], N);
    check({7'h00, irbit}, 8'h01);
    iop(Y, ACC_DIRECT, b, r, N, N, 8'h00, N);
    iop(Y, ACC_INDIRECT, 8'h80 | b, ~r, N, N, 8'h00, N);
    iop(N, ACC_INDIRECT, b, 8'h00, N, Y, r, N);
    iop(N, ACC_INDIRECT, 8'h80 | b, 8'h00, N, Y, ~r, N);
    iop(N, ACC_DIRECT, 8'h80 | b, 8'h00, N, N, 8'h00, Y);
    ptr(8'h12, 8'h34);
    sfr(N, N, Y, AUX_CONTROL_ADDR, 8'h00, 8'h00);
    sfr(Y, N, N, AUX_CONTROL_ADDR, 8'h00, 8'h01);
    ptr(8'h56, 8'h78);
    sfr(Y, N, N, PTR_HIGH_ADDR, 8'h00, 8'h56);
    sfr(N, Y, N, AUX_CONTROL_ADDR, 8'h08, 8'h00);
    sfr(Y, N, N, PTR_LOW_ADDR, 8'h00, 8'h34);
    @(negedge mclk) dinc = Y;
    @(negedge mclk) dinc = N;
    sfr(Y, N, N, PTR_LOW_ADDR, 8'h00, 8'h35);
    sfr(N, N, Y, AUX_CONTROL_ADDR, 8'h00, 8'h00);
    sfr(Y, N, N, AUX_CONTROL_ADDR, 8'h00, 8'h09);
    sfr(Y, N, N, PTR_LOW_ADDR, 8'h00, 8'h78);
    ptr(8'h07, 8'hff);
    xop(Y, Y, 8'h00, r, 8'h00);
    xop(N, Y, 8'h00, 8'h00, r);
    sfr(N, Y, N, AUX_CONFIG_ADDR, 8'h16, 8'h00);
    for (i = 0; i < 4; i++) begin
      r = 8'($urandom);
      h = 8'($urandom_range(255, 3));
      ptr(h, 8'(i));
      xop(Y, Y, 8'h00, r, 8'h00);
      check(last_hi, h);
      xop(N, Y, 8'h00, 8'h00, r);
      p2r = 8'($urandom);
      xop(Y, N, 8'(i + 8), ~r, 8'h00);
      check(last_hi, p2r);
      xop(N, N, 8'(i + 8), 8'h00, ~r);
    end
    sfr(N, Y, N, AUX_CONFIG_ADDR, 8'h36, 8'h00);
    slow = Y;
    ptr(8'h02, 8'h40);
    xop(Y, Y, 8'h00, r, 8'h00);
    xop(N, Y, 8'h00, 8'h00, r);
    slow = N;
    sfr(N, Y, N, AUX_CONFIG_ADDR, 8'h00, 8'h00);
    ptr(8'h01, 8'h00);
    xop(Y, Y, 8'h00, r, 8'h00);
    check(last_hi, 8'h01);
    ptr(8'h00, 8'hff);
    xop(Y, Y, 8'h00, r, 8'h00);
    check(last_hi, 8'h01);
    sfr(N, Y, N, AUX_CONFIG_ADDR, 8'h01, 8'h00);
    sfr(Y, N, N, AUX_CONFIG_ADDR, 8'h00, 8'h01);
    ptr(8'h01, 8'h00);
    xop(N, Y, 8'h00, 8'h00, r);
    give_verdict();
  end
endmodule : data_memory_space_decoder_tb

bind data_memory_space_decoder dmem_props chk (.mclk(mclk), .rst_n(rst_n),
  .int_req(int_req), .int_we(int_we), .int_mode(int_mode),
  .int_addr(int_addr), .sfr_wr(sfr_wr), .sfr_addr(sfr_addr),
  .sfr_wdata(sfr_wdata), .x_req(x_req), .busy(busy), .int_done(int_done),
  .direct_to_sfr(direct_to_sfr), .x_done(x_done), .ale(ale), .rd_n(rd_n),
  .wr_n(wr_n), .low_address_data_port_out(low_address_data_port_out),
  .low_address_data_port_oe(low_address_data_port_oe));

// File: tb/dmem_props.sv
`timescale 1ns/1ps
module dmem_props
  import dmem_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic int_req,
  input wire logic int_we,
  input wire acc_mode_t int_mode,
  input wire logic [7:0] int_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic x_req,
  input wire logic busy,
  input wire logic int_done,
  input wire logic direct_to_sfr,
  input wire logic x_done,
  input wire logic ale,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [7:0] low_address_data_port_out,
  input wire logic low_address_data_port_oe
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // ---------------------------------------------------------------
  // helper state
  // ---------------------------------------------------------------
  logic strb;
  logic take;
  logic to_sfr;
  logic stretch;
  logic ale_off;
  logic [4:0] low_cnt;
  assign strb = rd_n & wr_n;
  assign take = int_req && !busy && !x_req;
  assign to_sfr = int_addr[7] &&
    (int_mode == ACC_DIRECT || int_mode == ACC_BIT);
  // mirrors the stretch bit; increments of the config byte not tracked
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stretch <= 1'h0;
      ale_off <= AUX_CONFIG_RESET[ALE_DIS_BIT];
      low_cnt <= 5'h00;
    end else begin
      if (sfr_wr && sfr_addr == AUX_CONFIG_ADDR) begin
        stretch <= sfr_wdata[STRETCH_BIT];
        ale_off <= sfr_wdata[ALE_DIS_BIT];
      end
      low_cnt <= strb ? 5'h00 : low_cnt + 5'h01;
    end
  end
  sequence bus_tail_s;
    ##1 x_done && !busy;
  endsequence
  sequence int_take_s;
    take && !to_sfr && !(int_we && int_mode == ACC_BIT);
  endsequence
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  excl_strobes_a:
    assert property (rd_n || wr_n)
    else $error("read and write strobes low together");
  strobe_width_a:
    assert property ($rose(strb) |->
      low_cnt == (stretch ? STROBE_STRETCH : STROBE_NORMAL))
    else $error("strobe width wrong");
  addr_lead_a:
    assert property ($fell(strb) |-> $past(ale, 2))
    else $error("address strobe not two cycles before strobe");
  bus_end_a:
    assert property ($rose(strb) |-> bus_tail_s)
    else $error("bus cycle did not end after strobe");
  rd_release_a:
    assert property (!rd_n |-> !low_address_data_port_oe)
    else $error("port driven during read strobe");
  wdata_hold_a:
    assert property (!wr_n && !$past(wr_n) |->
      low_address_data_port_oe && $stable(low_address_data_port_out))
    else $error("write data moved during write strobe");
  sfr_direct_a:
    assert property (take && to_sfr |=> direct_to_sfr ##1 !int_done)
    else $error("direct upper access not diverted");
  int_latency_a:
    assert property (int_take_s |-> ##2 int_done)
    else $error("internal access latency wrong");
  // a new disable bit only reaches the strobe one edge after the write
  ale_quiet_a:
    assert property ($past(ale_off) && !busy |-> !ale)
    else $error("address strobe pulsed while disabled");
  // reset leaves the divider one pulse late, hence four samples
  ale_free_a:
    assert property (!$past(ale_off) && !ale_off && !busy |->
      ##[0:3] (ale || ale_off))
    else $error("address strobe not free running");
endmodule : dmem_props

// File: tb/ext_mem.sv
`timescale 1ns/1ps
module ext_mem (
  input wire logic mclk,
  input wire logic ale,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic slow,
  input wire logic [7:0] dout,
  input wire logic doe,
  input wire logic [7:0] hi,
  output logic [7:0] din,
  output logic [7:0] last_hi
);
  logic [7:0] mem [0:255];
  logic [7:0] lo;
  logic [7:0] prev = 8'h00;
  logic [4:0] dly;
  logic drive;
  always @(posedge mclk) begin
    if (ale) begin
      lo <= dout;
      last_hi <= hi;
    end
    if (!wr_n) mem[lo] <= dout;
    dly <= rd_n ? 5'h00 : dly + 5'h01;
    prev <= din;
  end
  // a slow device answers late; only a stretched strobe absorbs it
  assign drive = !rd_n && (!slow || dly >= 5'h08);
  // released bus toggles so stale data cannot pass as a read
  assign din = doe ? dout : (drive ? mem[lo] : ~prev);
endmodule : ext_mem
